/* include/epw_defines.svh */
// Offsets, field positions and reset values for the PWM output stage.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef EPW_DEFINES_SVH
`define EPW_DEFINES_SVH

// ==========================================
// Register byte offsets
`define EPW_OFF_CTRL      12'h000
`define EPW_OFF_DUTY_LO   12'h004
`define EPW_OFF_DUTY_HI   12'h008
`define EPW_OFF_STEER     12'h00c
`define EPW_OFF_PERIOD    12'h010
`define EPW_OFF_FLAG      12'h014
`define EPW_OFF_ALTPIN0   12'h018
`define EPW_OFF_ALTPIN1   12'h01c
`define EPW_OFF_DRVEN     12'h020
`define EPW_OFF_STATUS    12'h024

// ==========================================
// Field positions
`define EPW_CFG_HI_BIT    7
`define EPW_CFG_LO_BIT    6
`define EPW_DLSB_HI_BIT   5
`define EPW_DLSB_LO_BIT   4
`define EPW_MODE_HI       3
`define EPW_MODE_LO       0
`define EPW_STEER_SYNC    4
`define EPW_PWM_MODE      2'h3

// ==========================================
// Reset values
`define EPW_RST_CTRL      8'h00
`define EPW_RST_STEER     8'h01
`define EPW_RST_PERIOD    8'hff
`define EPW_RST_ALTPIN    8'h00
`define EPW_RST_DUTY      8'h00
`define EPW_RST_DRVEN     4'h0

`endif

/* include/epw_pkg.sv */
// Types shared by the PWM output stage files.
// Assumes epw_defines.svh supplies the numeric constants.
package epw_pkg;

    // ==========================================
    // Register and pin carriers
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] duty_lo;
        logic [7:0] duty_hi;
        logic [7:0] steer;
        logic [7:0] steer_act;
        logic [7:0] period;
        logic [7:0] alt0;
        logic [7:0] alt1;
        logic [3:0] drv_en;
        logic       flag;
        logic       steer_pend;
        logic [1:0] periods_seen;
    } epw_regs_s;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } epw_pins_s;

    typedef struct packed {
        logic [7:0] count;
        logic [9:0] frac;
        logic       wave;
    } epw_tmr_s;

endpackage

/* src/epw_timer.sv */
// PWM output stage: register file, steering, polarity, driver enables and period timer.
// Assumes an APB master on mclk and external switches with pull resistors on the pins.
`timescale 1ns/1ps
`include "epw_defines.svh"

// ==========================================
// Period timer
module epw_timer (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] period_value,
    input  wire logic [9:0] duty_value,
    // Results
    output logic            pwm_wave,
    output logic            period_start
);

    // ==========================================
    // State
    epw_pkg::epw_tmr_s q;
    epw_pkg::epw_tmr_s d;

    // ==========================================
    // Next state
    always_comb begin
        d            = q;
        period_start = 1'b0;
        if (!run) begin
            // Idle timer restarts from zero so the first period is whole
            d.count = 8'h00;
            d.frac  = duty_value;
            d.wave  = 1'b0;
        end else begin
            if (q.count == period_value) begin
                d.count      = 8'h00;
                // Duty only changes on a boundary, so no runt pulses
                d.frac       = duty_value;
                period_start = clk_en;
            end else begin
                d.count = 8'(q.count + 8'h01);
            end
            d.wave = ({q.count, 2'b00} < q.frac);
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q.count <= 8'h00;
            q.frac  <= 10'h000;
            q.wave  <= 1'b0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign pwm_wave = q.wave;

endmodule // epw_timer

// ==========================================
// Output stage top
module epw_top (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          arst_n,
    input  wire logic          clk_en,
    // Register bus
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    // Output pins
    output epw_pkg::epw_pins_s pin_out,
    output logic      [15:0]   pin_route
);

    // ==========================================
    // Declarations
    epw_pkg::epw_regs_s q;
    epw_pkg::epw_regs_s d;
    logic               wr_en;
    logic               steer_wr;
    logic               run;
    logic               period_start;
    logic               pwm_wave;
    logic [3:0]         pol_low;
    logic [9:0]         duty_value;

    // ==========================================
    // Functions
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    // Bit 1 sets pair A/C, bit 0 sets pair B/D; pin order is D C B A
    function automatic logic [3:0] pair_levels(input logic [1:0] sel);
        return {sel[0], sel[1], sel[0], sel[1]};
    endfunction

    // ==========================================
    // Bus decode
    // Zero wait states: every access completes in its first access cycle
    assign pready     = 1'b1;
    assign wr_en      = psel && penable && pwrite && clk_en;
    assign steer_wr   = wr_en && hit(paddr, `EPW_OFF_STEER);
    assign run        = (q.ctrl[`EPW_MODE_HI -: 2] == `EPW_PWM_MODE);
    assign pol_low    = pair_levels(q.ctrl[`EPW_MODE_LO +: 2]);
    assign duty_value = {q.duty_lo, q.ctrl[`EPW_DLSB_HI_BIT -: 2]};

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        // Software writes first, hardware events below override them, except that a steer write cancels the pending steer update
        if (wr_en) begin
            if (hit(paddr, `EPW_OFF_CTRL)) begin
                d.ctrl = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_DUTY_LO)) begin
                d.duty_lo = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_DUTY_HI)) begin
                d.duty_hi = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_PERIOD)) begin
                d.period = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_ALTPIN0)) begin
                d.alt0 = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_ALTPIN1)) begin
                d.alt1 = pwdata[7:0];
            end
            if (hit(paddr, `EPW_OFF_DRVEN)) begin
                d.drv_en = pwdata[3:0];
            end
            if (hit(paddr, `EPW_OFF_FLAG) && !pwdata[0]) begin
                d.flag = 1'b0;
            end
        end
        if (steer_wr) begin
            d.steer = pwdata[7:0];
            if (pwdata[`EPW_STEER_SYNC]) begin
                d.steer_pend = 1'b1;
            end else begin
                // Immediate path may cut a pulse short; that is the point
                d.steer_act  = pwdata[7:0];
                d.steer_pend = 1'b0;
            end
        end
        // Period boundary events
        if (period_start) begin
            d.duty_hi = q.duty_lo;
            // Set wins over a clear in the same cycle
            d.flag    = 1'b1;
            if (q.periods_seen != 2'h3) begin
                d.periods_seen = 2'(q.periods_seen + 2'h1);
            end
            if (q.steer_pend && !steer_wr) begin
                d.steer_act  = q.steer;
                d.steer_pend = 1'b0;
            end
        end
        if (!run) begin
            d.periods_seen = 2'h0;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q.ctrl         <= `EPW_RST_CTRL;
            q.duty_lo      <= `EPW_RST_DUTY;
            q.duty_hi      <= `EPW_RST_DUTY;
            q.steer        <= `EPW_RST_STEER;
            q.steer_act    <= `EPW_RST_STEER;
            q.period       <= `EPW_RST_PERIOD;
            q.alt0         <= `EPW_RST_ALTPIN;
            q.alt1         <= `EPW_RST_ALTPIN;
            q.drv_en       <= `EPW_RST_DRVEN;
            q.flag         <= 1'b0;
            q.steer_pend   <= 1'b0;
            q.periods_seen <= 2'h0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ==========================================
    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `EPW_OFF_CTRL: begin
                    prdata = {24'h00_0000, q.ctrl};
                end
                `EPW_OFF_DUTY_LO: begin
                    prdata = {24'h00_0000, q.duty_lo};
                end
                `EPW_OFF_DUTY_HI: begin
                    prdata = {24'h00_0000, q.duty_hi};
                end
                `EPW_OFF_STEER: begin
                    prdata = {24'h00_0000, q.steer};
                end
                `EPW_OFF_PERIOD: begin
                    prdata = {24'h00_0000, q.period};
                end
                `EPW_OFF_FLAG: begin
                    prdata = {31'h0000_0000, q.flag};
                end
                `EPW_OFF_ALTPIN0: begin
                    prdata = {24'h00_0000, q.alt0};
                end
                `EPW_OFF_ALTPIN1: begin
                    prdata = {24'h00_0000, q.alt1};
                end
                `EPW_OFF_DRVEN: begin
                    prdata = {28'h000_0000, q.drv_en};
                end
                `EPW_OFF_STATUS: begin
                    prdata = {25'h000_0000, q.steer_pend, q.periods_seen, q.steer_act[3:0]};
                end
                default: begin
                    prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================
    // Pins
    // Levels are a gate of flops only; drivers stay off until software asks
    always_comb begin
        pin_out.oe    = q.drv_en;
        pin_out.level = (q.steer_act[3:0] & {4{pwm_wave}}) ^ pol_low;
    end

    assign pin_route = {q.alt1, q.alt0};

    // ==========================================
    // Period timer
    epw_timer epw_timer_i (
        .mclk         (mclk),
        .arst_n       (arst_n),
        .clk_en       (clk_en),
        .run          (run),
        .period_value (q.period),
        .duty_value   (duty_value),
        .pwm_wave     (pwm_wave),
        .period_start (period_start)
    );

endmodule // epw_top

/* tb/epw_properties.sv */
// Checker for the PWM output stage, watching only the top ports.
// Assumes zero-wait-state bus writes and the pin order D C B A.
`timescale 1ns/1ps
`include "epw_defines.svh"
module epw_properties (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               arst_n,
    input wire logic               clk_en,
    // Register bus
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    // Pins
    input wire epw_pkg::epw_pins_s pin_out,
    input wire logic [15:0]        pin_route
);
    // ==========================================
    // Shadow of the control register
    logic       wr;
    logic [7:0] ctrl_q;
    logic       mode_off;
    logic [3:0] pol;
    assign wr = psel && penable && pready && pwrite && clk_en;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 8'h00;
        end else if (wr && paddr == `EPW_OFF_CTRL) begin
            ctrl_q <= pwdata[7:0];
        end
    end
    assign mode_off = (ctrl_q[3:2] != 2'h3);
    assign pol      = {ctrl_q[0], ctrl_q[1], ctrl_q[0], ctrl_q[1]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // Assertions
    a_oe_after_reset: assert property (
        $rose(arst_n) |-> pin_out.oe == 4'h0) else $error("driver on after reset");
    a_oe_hold_steady: assert property (
        !(wr && paddr == `EPW_OFF_DRVEN) |=> $stable(pin_out.oe))
        else $error("driver enable changed without write");
    a_route_hold_steady: assert property (
        !(wr && (paddr == `EPW_OFF_ALTPIN0 || paddr == `EPW_OFF_ALTPIN1))
        |=> $stable(pin_route)) else $error("pin route changed without write");
    a_steer_now_off: assert property (
        (wr && paddr == `EPW_OFF_STEER && !pwdata[`EPW_STEER_SYNC])
        |=> ((pin_out.level ^ pol) & ~$past(pwdata[3:0])) == 4'h0)
        else $error("unsteered pin active after immediate steer");
    a_idle_inactive_level: assert property (
        (mode_off && $past(mode_off) && $past(clk_en)) |-> pin_out.level == pol)
        else $error("pin not at inactive level while idle");
    a_pair_level_match: assert property (
        (mode_off && $past(mode_off) && $past(clk_en))
        |-> (pin_out.level[0] == pin_out.level[2]) && (pin_out.level[1] == pin_out.level[3]))
        else $error("pair levels differ while idle");

    // ==========================================
    // Covers
    c_sync_write: cover property (wr && paddr == `EPW_OFF_STEER && pwdata[`EPW_STEER_SYNC]);
    c_drivers_on: cover property (pin_out.oe == 4'hf);
    c_wave_seen:  cover property (pin_out.level != pol);
endmodule // epw_properties

/* tb/epw_switch.sv */
// Model of the external power switches on the four PWM pins.
// Assumes a pull-down on every pin, so an undriven pin keeps its switch off.
`timescale 1ns/1ps
module epw_switch (
    // Pin side
    input  wire logic [3:0] level,
    input  wire logic [3:0] oe,
    // Switch state
    output logic      [3:0] switch_on
);
    // Undriven pins fall to the pull-down level
    assign switch_on = oe & level;
endmodule // epw_switch

/* tb/testbench.sv */
// Testbench for the PWM output stage: bus master, pin checks and verdict.
// Assumes epw_top answers every access in its first access cycle.
`timescale 1ns/1ps
`include "epw_defines.svh"
module testbench;
    // ==========================================
    // Signals
    logic               mclk      = 1'b0;
    logic               arst_n    = 1'b0;
    logic               clk_en    = 1'b1;
    logic               psel      = 1'b0;
    logic               penable   = 1'b0;
    logic               pwrite    = 1'b0;
    logic [11:0]        paddr     = 12'h000;
    logic [31:0]        pwdata    = 32'h0000_0000;
    logic [31:0]        prdata;
    logic               pready;
    epw_pkg::epw_pins_s pin_out;
    logic [15:0]        pin_route;
    logic [3:0]         switch_on;
    logic [31:0]        exp_q[$];
    int                 err_total = 0;
    int                 compares  = 0;
    logic [1:0]         pol;
    logic [3:0]         pol_pins;
    logic [7:0]         per;
    logic [7:0]         rnd0;
    logic [7:0]         rnd1;

    always #5 mclk = ~mclk;

    epw_top epw_top_i (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pin_out   (pin_out),
        .pin_route (pin_route)
    );

    epw_switch epw_switch_i (
        .level     (pin_out.level),
        .oe        (pin_out.oe),
        .switch_on (switch_on)
    );

    // ==========================================
    // Tasks
    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_read(input string name, input logic [31:0] exp,
                              input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic check_pins(input string name, input logic [3:0] exp,
                              input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask

    // Setup cycle, then access until pready is seen high at a rising edge
    task automatic apb_xfer(input logic wr, input logic [11:0] addr,
                            input logic [31:0] data);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_write(input logic [11:0] addr, input logic [31:0] data);
        apb_xfer(1'b1, addr, data);
    endtask

    task automatic apb_read(input logic [11:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb_xfer(1'b0, addr, 32'h0000_0000);
    endtask

    // ==========================================
    // Read monitor
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() > 0) begin
                check_read("read data", exp_q.pop_front(), prdata);
            end else begin
                err_total++;
                $display("CHECK FAILED read data exp none got %h", prdata);
            end
        end
    end

    // ==========================================
    // Stimulus
    initial begin
        void'($urandom(32'hf9ef));
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check_pins("oe after reset", 4'h0, pin_out.oe);
        check_pins("switch after reset", 4'h0, switch_on);
        apb_read(`EPW_OFF_STEER, 32'h0000_0001);
        apb_read(`EPW_OFF_PERIOD, 32'h0000_00ff);
        pol      = 2'($urandom);
        pol_pins = {pol[0], pol[1], pol[0], pol[1]};
        per      = 8'h03 + 8'($urandom % 4);
        rnd0     = 8'($urandom);
        rnd1     = 8'($urandom);
        apb_write(`EPW_OFF_CTRL, {30'h0000_0000, pol});
        repeat (2) @(posedge mclk);
        check_pins("idle level", pol_pins, pin_out.level);
        apb_write(`EPW_OFF_PERIOD, {24'h00_0000, per});
        apb_write(`EPW_OFF_DUTY_LO, {24'h00_0000, rnd0});
        apb_read(`EPW_OFF_DUTY_LO, {24'h00_0000, rnd0});
        apb_write(`EPW_OFF_STEER, 32'h0000_000f);
        apb_write(`EPW_OFF_CTRL, {28'h000_0000, 2'h3, pol});
        repeat (2 * (per + 1) + 4) @(posedge mclk);
        apb_read(`EPW_OFF_FLAG, 32'h0000_0001);
        apb_write(`EPW_OFF_DRVEN, 32'h0000_000f);
        @(posedge mclk);
        check_pins("oe enabled", 4'hf, pin_out.oe);
        apb_write(`EPW_OFF_STEER, 32'h0000_0000);
        @(posedge mclk);
        check_pins("steer off now", pol_pins, pin_out.level);
        check_pins("switch idle", pol_pins, switch_on);
        apb_write(`EPW_OFF_STEER, 32'h0000_001f);
        @(posedge mclk);
        check_pins("steer held", pol_pins, pin_out.level);
        repeat (2 * (per + 1)) @(posedge mclk);
        apb_read(`EPW_OFF_STATUS, 32'h0000_003f);
        apb_read(`EPW_OFF_STEER, 32'h0000_001f);
        clk_en <= 1'b0;
        apb_write(`EPW_OFF_PERIOD, 32'h0000_0055);
        clk_en <= 1'b1;
        apb_read(`EPW_OFF_PERIOD, {24'h00_0000, per});
        apb_write(`EPW_OFF_ALTPIN0, {24'h00_0000, rnd0});
        apb_write(`EPW_OFF_ALTPIN1, {24'h00_0000, rnd1});
        @(posedge mclk);
        check_read("pin route", {16'h0000, rnd1, rnd0}, {16'h0000, pin_route});
        apb_read(`EPW_OFF_ALTPIN1, {24'h00_0000, rnd1});
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check_pins("oe after second reset", 4'h0, pin_out.oe);
        apb_read(`EPW_OFF_STEER, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        tally_and_finish;
    end

    // ==========================================
    // Watchdog: the tests take 115 to 127 cycles
    initial begin
        #20000;
        err_total++;
        tally_and_finish;
    end
endmodule // testbench

bind epw_top epw_properties epw_properties_i (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .pin_out   (pin_out),
    .pin_route (pin_route)
);
